// ==== include/fpdp_tx_consts.svh ====
// Register offsets, field positions, reset values and strobe timing for the frame transmitter
`ifndef FPDP_TX_CONSTS_SVH
`define FPDP_TX_CONSTS_SVH

// Register offsets (byte addresses)
`define FTX_ADDR_W            4
`define FTX_OFS_CONTROL       4'h0
`define FTX_OFS_FRAME_LEN     4'h4
`define FTX_OFS_STROBE_DIV    4'h8
`define FTX_OFS_STATUS        4'hC

// Control register fields
`define FTX_CR_UNIT_ENABLE    4
`define FTX_CR_TRIG_SOURCE    6
`define FTX_CR_FMT_LO         8
`define FTX_CR_FMT_HI         9
`define FTX_CR_TRIG_SENSE     11
`define FTX_CR_SOFT_TRIGGER   12
`define FTX_CR_PACKED         13
`define FTX_CR_ENHANCED       14
`define FTX_CR_WMASK          32'h0000_6B50
`define FTX_CR_RESET          32'h0000_0000

// Frame length register
`define FTX_FLEN_W            12
`define FTX_FLEN_MAX          12'h800
`define FTX_FLEN_RESET        12'h800

// Strobe divider register: half period in system clocks
`define FTX_DIV_W             3
`define FTX_DIV_RESET         3'h1

// Strobe rates in MHz
`define FTX_SYS_CLK_MHZ       100
`define FTX_STROBE_MAX_MHZ    50
`define FTX_STROBE_MIN_LEG_MHZ 10
`define FTX_STROBE_MIN_ENH_MHZ 20

// Derived half-period limits; slowest rounds down, fastest rounds up
`define FTX_DIV_MIN  ((`FTX_SYS_CLK_MHZ + 2*`FTX_STROBE_MAX_MHZ - 1) / (2*`FTX_STROBE_MAX_MHZ))
`define FTX_DIV_MAX_LEG  (`FTX_SYS_CLK_MHZ / (2*`FTX_STROBE_MIN_LEG_MHZ))
`define FTX_DIV_MAX_ENH  (`FTX_SYS_CLK_MHZ / (2*`FTX_STROBE_MIN_ENH_MHZ))

`endif

// ==== include/fpdp_tx_pkg.sv ====
// Types shared by the frame transmitter modules
package fpdp_tx_pkg;

  typedef enum logic [1:0] {
    FMT_UNFRAMED,
    FMT_SINGLE,
    FMT_REPEAT,
    FMT_DYNAMIC
  } frame_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_RUN,
    ST_DONE
  } tx_state_t;

endpackage

// ==== include/strobe_if.sv ====
// Strobe timing link between the transmit core and the strobe generator
`timescale 1ns/10ps
`default_nettype none
interface strobe_if;
  logic [2:0] half_div;
  logic       strobe;
  logic       tick;

  modport gen  (input half_div, output strobe, output tick);
  modport core (output half_div, input strobe, input tick);
endinterface
`default_nettype wire

// ==== rtl/fpdp_strobe_gen.sv ====
// Strobe generator: divides the system clock into the link strobe
`timescale 1ns/10ps
`default_nettype none
`include "fpdp_tx_consts.svh"
module fpdp_strobe_gen (
  // Clock and reset
  input  wire logic    i_clk_sys,
  input  wire logic    i_rst_n,
  // Strobe timing
  strobe_if.gen        sif
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       strb_r;
  logic       strb_nxt;
  logic       wrap_w;

  // Half period elapsed
  assign wrap_w = (cnt_r >= (sif.half_div - 3'h1));

  always_comb begin
    cnt_nxt  = cnt_r + 3'h1;
    strb_nxt = strb_r;
    if (wrap_w) begin
      cnt_nxt  = 3'h0;
      strb_nxt = ~strb_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_r  <= 3'h0;
      strb_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      strb_r <= strb_nxt;
    end
  end

  // Tick marks the falling strobe edge, where new data is launched
  assign sif.strobe = strb_r;
  assign sif.tick   = wrap_w & strb_r; // RULE_17

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_tick_falls: assert property (sif.tick |=> !sif.strobe) // RULE_17
    else $error("strobe did not fall after tick");
  a_strobe_toggle: assert property ( // RULE_17
    $past(i_rst_n) && (sif.half_div == 3'h1 && $past(sif.half_div) == 3'h1)
    |-> (sif.strobe != $past(sif.strobe)))
    else $error("strobe not toggling at full rate");
  c_full_rate: cover property (sif.half_div == 3'h1 ##1 sif.tick ##2 sif.tick);

endmodule
`default_nettype wire

// ==== rtl/fpdp_trigger_frame_tx.sv ====
// Front-panel transmit control: trigger gating, framing and strobe-paced data output
// Summary of operation
// RULE_01 - No word leaves the port until a trigger has been received.
// RULE_02 - Control bit 6 picks software trigger or external trigger input.
// RULE_03 - With software source, writing one to control bit 12 triggers.
// RULE_04 - Control bit 11 picks edge or level sense for external trigger.
// RULE_05 - Edge sense starts transmission after a rising trigger edge.
// RULE_06 - External edge trigger must stay high two strobe periods.
// RULE_07 - Level sense sends only while trigger is high.
// RULE_08 - Level low stops output at once, even mid-frame.
// RULE_09 - Level resume continues at the halted word; sync stays at frame end.
// RULE_10 - Level trigger may toggle freely without reconfiguration.
// RULE_11 - Software uses edge sense for one-shot modes.
// RULE_12 - Frame length programmable from 1 to 2048 words.
// RULE_13 - Unframed, single-frame and fixed repeating frames supported.
// RULE_14 - Software sets frame format before triggering.
// RULE_15 - Detected legacy receiver forces legacy operation.
// RULE_16 - Software selects enhanced or legacy operation.
// RULE_17 - Device makes the strobe, 50 MHz max, 10 or 20 MHz min.
// RULE_18 - One 32-bit word per strobe cycle on the parallel path.
// RULE_19 - Packed and unpacked data arrangements supported.
// RULE_20 - Receiver suspend and strobe rate pace the output.
// RULE_21 - Control bit 4 enables; clearing it stops every mode.
// RULE_22 - External trigger is synchronised before edge detection.
// RULE_23 - Frame counter places the sync marker on the last word.
`timescale 1ns/10ps
`default_nettype none
`include "fpdp_tx_consts.svh"
module fpdp_trigger_frame_tx (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // Data source
  input  wire logic [31:0] i_src_data,
  input  wire logic        i_src_valid,
  output logic             o_src_ready,
  // Link pins from receivers
  input  wire logic        i_external_trigger_input,
  input  wire logic        i_suspend_n,
  input  wire logic        i_legacy_rx_present,
  // Link pins to receivers
  output logic      [31:0] o_link_data,
  output logic             o_data_valid,
  output logic             o_frame_sync,
  output logic             o_ttl_strobe_out,
  output logic             o_pecl_strobe_pair_p,
  output logic             o_pecl_strobe_pair_n,
  output logic             o_enhanced_mode,
  output logic             o_packed_mode
);

  strobe_if sif ();

  fpdp_strobe_gen u_strobe (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .sif       (sif)
  );

  // Input synchronisers
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       ext_d_r;
  logic       ext_s;
  logic       susp_s;
  logic       legacy_s;
  logic       ext_rise_w;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      ext_d_r <= 1'b0;
    end else begin
      sync1_r <= {i_legacy_rx_present, ~i_suspend_n, i_external_trigger_input}; // RULE_22
      sync2_r <= sync1_r;
      ext_d_r <= sync2_r[0];
    end
  end

  assign ext_s      = sync2_r[0];
  assign susp_s     = sync2_r[1];
  assign legacy_s   = sync2_r[2];
  assign ext_rise_w = ext_s & ~ext_d_r; // RULE_22

  // Register file
  logic [31:0]               ctrl_r;
  logic [31:0]               ctrl_nxt;
  logic [`FTX_FLEN_W-1:0]    flen_r;
  logic [`FTX_FLEN_W-1:0]    flen_nxt;
  logic [`FTX_DIV_W-1:0]     div_r;
  logic [`FTX_DIV_W-1:0]     div_nxt;
  logic [31:0]               rdata_r;
  logic [31:0]               rdata_nxt;
  logic                      soft_trig_w;

  logic                      enable_w;
  logic                      src_ext_w;
  logic                      sense_lvl_w;
  logic                      enh_active_w;
  fpdp_tx_pkg::frame_fmt_t   fmt_w;

  fpdp_tx_pkg::tx_state_t    state_r;
  fpdp_tx_pkg::tx_state_t    state_nxt;
  logic [`FTX_FLEN_W-1:0]    cnt_r;
  logic [`FTX_FLEN_W-1:0]    cnt_nxt;
  logic [31:0]               data_r;
  logic [31:0]               data_nxt;
  logic                      valid_r;
  logic                      valid_nxt;
  logic                      sync_r;
  logic                      sync_nxt;
  logic                      redo_r;
  logic                      redo_nxt;

  // Clamp frame length into 1..2048
  function automatic logic [`FTX_FLEN_W-1:0] eff_len(input logic [`FTX_FLEN_W-1:0] len);
    logic [`FTX_FLEN_W-1:0] res;
    res = len;
    if (len == 12'h000) begin
      res = 12'h001;
    end else if (len > `FTX_FLEN_MAX) begin
      res = `FTX_FLEN_MAX;
    end
    return res;
  endfunction

  // Clamp strobe half period to the mode's rate limits
  function automatic logic [`FTX_DIV_W-1:0] eff_div(input logic [`FTX_DIV_W-1:0] div,
                                                    input logic enh);
    logic [`FTX_DIV_W-1:0] lo;
    logic [`FTX_DIV_W-1:0] hi;
    logic [`FTX_DIV_W-1:0] res;
    lo  = `FTX_DIV_W'(`FTX_DIV_MIN);
    hi  = enh ? `FTX_DIV_W'(`FTX_DIV_MAX_ENH) : `FTX_DIV_W'(`FTX_DIV_MAX_LEG);
    res = div;
    if (div < lo) begin
      res = lo;
    end else if (div > hi) begin
      res = hi;
    end
    return res;
  endfunction

  assign enable_w     = ctrl_r[`FTX_CR_UNIT_ENABLE];
  assign src_ext_w    = ctrl_r[`FTX_CR_TRIG_SOURCE]; // RULE_02
  assign sense_lvl_w  = ctrl_r[`FTX_CR_TRIG_SENSE]; // RULE_04
  assign fmt_w        = fpdp_tx_pkg::frame_fmt_t'(ctrl_r[`FTX_CR_FMT_HI:`FTX_CR_FMT_LO]);
  assign enh_active_w = ctrl_r[`FTX_CR_ENHANCED] & ~legacy_s; // RULE_15 RULE_16
  assign soft_trig_w  = i_reg_wr && (i_reg_addr == `FTX_OFS_CONTROL)
                        && i_reg_wdata[`FTX_CR_SOFT_TRIGGER]; // RULE_03

  assign sif.half_div = eff_div(div_r, enh_active_w); // RULE_17

  always_comb begin
    ctrl_nxt  = ctrl_r;
    flen_nxt  = flen_r;
    div_nxt   = div_r;
    rdata_nxt = 32'h0000_0000;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `FTX_OFS_CONTROL: begin
          ctrl_nxt = i_reg_wdata & `FTX_CR_WMASK;
        end
        `FTX_OFS_FRAME_LEN: begin
          flen_nxt = i_reg_wdata[`FTX_FLEN_W-1:0]; // RULE_12
        end
        `FTX_OFS_STROBE_DIV: begin
          div_nxt = i_reg_wdata[`FTX_DIV_W-1:0];
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `FTX_OFS_CONTROL: begin
          rdata_nxt = ctrl_r;
        end
        `FTX_OFS_FRAME_LEN: begin
          rdata_nxt = {20'h00000, flen_r};
        end
        `FTX_OFS_STROBE_DIV: begin
          rdata_nxt = {29'h0, div_r};
        end
        `FTX_OFS_STATUS: begin
          rdata_nxt = {8'h00, 2'(state_r), enh_active_w, legacy_s, susp_s, ext_s,
                       valid_r, 5'h00, cnt_r};
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl_r  <= `FTX_CR_RESET;
      flen_r  <= `FTX_FLEN_RESET;
      div_r   <= `FTX_DIV_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      flen_r  <= flen_nxt;
      div_r   <= div_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Trigger and transmit sequencing
  logic                   trig_fire_w;
  logic                   gate_w;
  logic                   go_w;
  logic                   send_w;
  logic                   last_w;
  logic                   framed_w;
  logic [`FTX_FLEN_W-1:0] len_w;

  assign len_w    = eff_len(flen_r);
  assign last_w   = (cnt_r == (len_w - 12'h001)); // RULE_23
  assign framed_w = (fmt_w == fpdp_tx_pkg::FMT_SINGLE) || (fmt_w == fpdp_tx_pkg::FMT_REPEAT); // RULE_13

  always_comb begin
    if (!src_ext_w) begin
      trig_fire_w = soft_trig_w; // RULE_03
    end else if (sense_lvl_w) begin
      trig_fire_w = 1'b1; // RULE_10
    end else begin
      trig_fire_w = ext_rise_w; // RULE_05
    end
  end

  assign gate_w = !(src_ext_w && sense_lvl_w) || ext_s; // RULE_07
  assign go_w   = (state_r == fpdp_tx_pkg::ST_RUN) && enable_w && gate_w && !susp_s
                  && (i_src_valid || redo_r); // RULE_01 RULE_20
  assign send_w = go_w && sif.tick; // RULE_18 RULE_20

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    data_nxt  = data_r;
    valid_nxt = valid_r;
    sync_nxt  = sync_r;
    redo_nxt  = redo_r;
    case (state_r)
      fpdp_tx_pkg::ST_IDLE: begin
        cnt_nxt = 12'h000;
        if (enable_w) begin
          state_nxt = fpdp_tx_pkg::ST_WAIT_TRIG;
        end
      end
      fpdp_tx_pkg::ST_WAIT_TRIG: begin
        if (trig_fire_w) begin
          state_nxt = fpdp_tx_pkg::ST_RUN; // RULE_01
        end
      end
      fpdp_tx_pkg::ST_RUN: begin
        if (send_w && redo_r) begin
          // Re-present the word cut off before the receiver strobed it
          valid_nxt = 1'b1; // RULE_09
          sync_nxt  = framed_w && (cnt_r == 12'h000);
          redo_nxt  = 1'b0;
        end else if (send_w) begin
          data_nxt  = ctrl_r[`FTX_CR_PACKED] ? i_src_data : {16'h0000, i_src_data[15:0]}; // RULE_19
          valid_nxt = 1'b1;
          sync_nxt  = framed_w && last_w; // RULE_23 RULE_09
          cnt_nxt   = last_w ? 12'h000 : (cnt_r + 12'h001); // RULE_09
          if (last_w && (fmt_w == fpdp_tx_pkg::FMT_SINGLE)) begin
            state_nxt = fpdp_tx_pkg::ST_DONE; // RULE_13
          end
        end else if (sif.tick) begin
          valid_nxt = 1'b0;
          sync_nxt  = 1'b0;
        end
      end
      fpdp_tx_pkg::ST_DONE: begin
        if (sif.tick) begin
          valid_nxt = 1'b0;
          sync_nxt  = 1'b0;
        end
        if (trig_fire_w && !(src_ext_w && sense_lvl_w)) begin
          state_nxt = fpdp_tx_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = fpdp_tx_pkg::ST_IDLE;
      end
    endcase
    if (!gate_w) begin
      valid_nxt = 1'b0; // RULE_08
      if ((state_r == fpdp_tx_pkg::ST_RUN) && valid_r && !sif.strobe) begin
        redo_nxt = 1'b1; // RULE_09
      end
      sync_nxt  = 1'b0;
    end
    if (!enable_w) begin
      state_nxt = fpdp_tx_pkg::ST_IDLE; // RULE_21
      redo_nxt  = 1'b0;
      cnt_nxt   = 12'h000;
      valid_nxt = 1'b0;
      sync_nxt  = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_r <= fpdp_tx_pkg::ST_IDLE;
      cnt_r   <= 12'h000;
      data_r  <= 32'h0000_0000;
      valid_r <= 1'b0;
      sync_r  <= 1'b0;
      redo_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      data_r  <= data_nxt;
      valid_r <= valid_nxt;
      sync_r  <= sync_nxt;
      redo_r  <= redo_nxt;
    end
  end

  // Outputs
  assign o_reg_rdata          = rdata_r;
  assign o_src_ready          = send_w && !redo_r;
  assign o_link_data          = data_r;
  assign o_data_valid         = valid_r;
  assign o_frame_sync         = sync_r;
  assign o_ttl_strobe_out     = sif.strobe;
  assign o_pecl_strobe_pair_p = sif.strobe;
  assign o_pecl_strobe_pair_n = ~sif.strobe;
  assign o_enhanced_mode      = enh_active_w;
  assign o_packed_mode        = ctrl_r[`FTX_CR_PACKED];

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_hold_until_trig: assert property ( // RULE_01
    (state_r == fpdp_tx_pkg::ST_WAIT_TRIG) && !trig_fire_w |=> !o_src_ready)
    else $error("word taken before trigger");
  a_soft_trig_run: assert property ( // RULE_03
    (state_r == fpdp_tx_pkg::ST_WAIT_TRIG) && enable_w && !src_ext_w
    && soft_trig_w && i_reg_wdata[`FTX_CR_UNIT_ENABLE] |=> (state_r == fpdp_tx_pkg::ST_RUN))
    else $error("software trigger did not start transmission");
  a_ext_src_ignores_soft: assert property ( // RULE_02
    (state_r == fpdp_tx_pkg::ST_WAIT_TRIG) && src_ext_w && !sense_lvl_w && !ext_rise_w
    |=> (state_r != fpdp_tx_pkg::ST_RUN))
    else $error("started without external edge");
  a_edge_trig_run: assert property ( // RULE_05
    (state_r == fpdp_tx_pkg::ST_WAIT_TRIG) && enable_w && src_ext_w && !sense_lvl_w
    && ext_rise_w && !i_reg_wr |=> (state_r == fpdp_tx_pkg::ST_RUN))
    else $error("external rising edge missed");
  a_level_stop_now: assert property ( // RULE_08
    src_ext_w && sense_lvl_w && !ext_s |=> !o_data_valid && !o_frame_sync)
    else $error("output continued with level trigger low");
  a_level_resume_word: assert property ( // RULE_09
    (state_r == fpdp_tx_pkg::ST_RUN) && !gate_w && enable_w && !i_reg_wr |=> $stable(cnt_r))
    else $error("word position lost while paused");
  a_sync_on_last: assert property ( // RULE_23
    o_src_ready && framed_w && last_w |=> o_frame_sync && o_data_valid)
    else $error("sync missing on final frame word");
  a_no_sync_unframed: assert property ( // RULE_13
    send_w && !framed_w |=> !o_frame_sync)
    else $error("sync in unframed output");
  a_disable_stops: assert property ( // RULE_21
    !enable_w |=> (state_r == fpdp_tx_pkg::ST_IDLE) && !o_data_valid)
    else $error("transmitter not stopped by disable");
  a_legacy_fallback: assert property ( // RULE_15
    legacy_s |-> !o_enhanced_mode)
    else $error("enhanced mode with legacy receiver");
  a_word_launch: assert property ( // RULE_18
    o_src_ready |=> o_data_valid && (o_link_data[15:0] == $past(i_src_data[15:0])))
    else $error("accepted word not presented");
  a_suspend_pace: assert property ( // RULE_20
    susp_s |-> !o_src_ready)
    else $error("word taken during suspend");

  c_soft_send: cover property (soft_trig_w ##[1:40] o_src_ready);
  c_level_pause: cover property (o_data_valid && src_ext_w && sense_lvl_w ##1 !ext_s ##[1:60] o_data_valid);
  c_frame_sync: cover property (o_frame_sync && fmt_w == fpdp_tx_pkg::FMT_REPEAT);
  c_single_done: cover property (state_r == fpdp_tx_pkg::ST_DONE);

endmodule
`default_nettype wire

// ==== testbench/fpdp_rx_model.sv ====
// Behavioural front-panel receiver: captures words on the strobe and drives suspend
`timescale 1ns/10ps
`default_nettype none
module fpdp_rx_model (
  // Link from transmitter
  input  wire logic        i_strobe,
  input  wire logic [31:0] i_link_data,
  input  wire logic        i_data_valid,
  input  wire logic        i_frame_sync,
  // Test control
  input  wire logic        i_hold,
  // Link to transmitter
  output logic             o_suspend_n
);
  logic [31:0] words[$];
  logic        syncs[$];

  // Suspend is active low while the bench asks the receiver to stall
  assign o_suspend_n = !i_hold;

  // Capture on the rising strobe while the word is valid
  always @(posedge i_strobe) begin
    if (i_data_valid === 1'b1) begin
      words.push_back(i_link_data);
      syncs.push_back(i_frame_sync);
    end
  end

  task automatic clr();
    words.delete();
    syncs.delete();
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_fpdp_trigger_frame_tx.sv ====
// Testbench for the front-panel frame transmitter
`timescale 1ns/10ps
`default_nettype none
`include "fpdp_tx_consts.svh"
module tb_fpdp_trigger_frame_tx;
  localparam logic [31:0] EN  = 32'h0000_0001 << `FTX_CR_UNIT_ENABLE;
  localparam logic [31:0] EXT = 32'h0000_0001 << `FTX_CR_TRIG_SOURCE;
  localparam logic [31:0] LVL = 32'h0000_0001 << `FTX_CR_TRIG_SENSE;
  localparam logic [31:0] TRG = 32'h0000_0001 << `FTX_CR_SOFT_TRIGGER;
  localparam logic [31:0] PK  = 32'h0000_0001 << `FTX_CR_PACKED;
  localparam logic [31:0] ENH = 32'h0000_0001 << `FTX_CR_ENHANCED;
  localparam logic [31:0] SGL = 32'h0000_0001 << `FTX_CR_FMT_LO;
  localparam logic [31:0] RPT = 32'h0000_0001 << `FTX_CR_FMT_HI;

  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [31:0] src_data = 32'hA5C3_0000;
  logic        src_valid;
  logic        src_ready;
  logic        pin;
  logic        hold;
  logic        suspend_n;
  logic        legacy;
  logic [31:0] link_data;
  logic        valid;
  logic        sync;
  logic        strobe;
  logic        pecl_p;
  logic        pecl_n;
  logic        enh;
  logic        packed_md;
  int          error_cnt;
  int          n_compared;
  logic [31:0] base;
  logic [31:0] rv;
  int          n;
  realtime     t0;

  fpdp_trigger_frame_tx i_fpdp_trigger_frame_tx (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_src_data(src_data),
    .i_src_valid(src_valid), .o_src_ready(src_ready), .i_external_trigger_input(pin),
    .i_suspend_n(suspend_n), .i_legacy_rx_present(legacy), .o_link_data(link_data),
    .o_data_valid(valid), .o_frame_sync(sync), .o_ttl_strobe_out(strobe),
    .o_pecl_strobe_pair_p(pecl_p), .o_pecl_strobe_pair_n(pecl_n),
    .o_enhanced_mode(enh), .o_packed_mode(packed_md));

  fpdp_rx_model i_fpdp_rx_model (
    .i_strobe(strobe), .i_link_data(link_data), .i_data_valid(valid),
    .i_frame_sync(sync), .i_hold(hold), .o_suspend_n(suspend_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Source advances one word each time the transmitter takes one
  always @(posedge clk) begin
    if (src_ready === 1'b1) src_data <= src_data + 32'h0000_0001;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic wait_words(input int w);
    for (int k = 0; k < 3000 && i_fpdp_rx_model.words.size() < w; k++) @(posedge clk);
  endtask

  function automatic logic [31:0] cnt();
    return 32'(i_fpdp_rx_model.words.size());
  endfunction

  task automatic chk_stream(input logic [31:0] b, input int flen, input bit pk, input bit fr);
    logic [31:0] v;
    for (int i = 0; i < i_fpdp_rx_model.words.size(); i++) begin
      v = b + 32'(i);
      chk("link word", pk ? v : {16'h0000, v[15:0]}, i_fpdp_rx_model.words[i]);
      chk("frame sync", {31'h0, fr && (i % flen == flen - 1)}, {31'h0, i_fpdp_rx_model.syncs[i]});
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d compared, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    $display("MISMATCH watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    rst_n = 1'b0; addr = 4'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    src_valid = 1'b1; pin = 1'b0; hold = 1'b0; legacy = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("pecl n idle", 32'h1, {31'h0, pecl_n});
    rd_chk("control", `FTX_OFS_CONTROL, `FTX_CR_RESET);
    rd_chk("frame len", `FTX_OFS_FRAME_LEN, {20'h0, `FTX_FLEN_RESET});
    rd_chk("divider", `FTX_OFS_STROBE_DIV, {29'h0, `FTX_DIV_RESET});
    rd_chk("unmapped", 4'h2, 32'h0);
    $display("TEST reset done");
    // Software trigger, single unpacked frame of 3
    reg_wr(`FTX_OFS_FRAME_LEN, 32'h0000_0003);
    reg_wr(`FTX_OFS_CONTROL, EN | SGL);
    cycles(60);
    chk("words before trigger", 32'h0, cnt());
    base = src_data;
    reg_wr(`FTX_OFS_CONTROL, EN | SGL | TRG);
    wait_words(3);
    cycles(60);
    chk("single count", 32'h3, cnt());
    chk_stream(base, 3, 1'b0, 1'b1);
    reg_rd(`FTX_OFS_STATUS, rv);
    chk("state done", 32'h3, {30'h0, rv[23:22]});
    $display("TEST soft single done");
    // External edge trigger, packed single frame of 2, twice
    reg_wr(`FTX_OFS_CONTROL, 32'h0);
    reg_wr(`FTX_OFS_FRAME_LEN, 32'h0000_0002);
    reg_wr(`FTX_OFS_CONTROL, EN | EXT | SGL | PK);
    i_fpdp_rx_model.clr();
    reg_wr(`FTX_OFS_CONTROL, EN | EXT | SGL | PK | TRG);
    cycles(60);
    chk("soft with ext source", 32'h0, cnt());
    for (int f = 0; f < 2; f++) begin
      base = src_data;
      i_fpdp_rx_model.clr();
      pin <= 1'b1;
      cycles(10);
      pin <= 1'b0;
      wait_words(2);
      cycles(60);
      chk("edge count", 32'h2, cnt());
      chk_stream(base, 2, 1'b1, 1'b1);
    end
    $display("TEST edge trigger done");
    // Repeating packed frames of 4, strobe rate, suspend and disable
    reg_wr(`FTX_OFS_CONTROL, 32'h0);
    reg_wr(`FTX_OFS_FRAME_LEN, 32'h0000_0004);
    reg_wr(`FTX_OFS_STROBE_DIV, 32'h0000_0002);
    reg_wr(`FTX_OFS_CONTROL, EN | RPT | PK);
    i_fpdp_rx_model.clr();
    base = src_data;
    reg_wr(`FTX_OFS_CONTROL, EN | RPT | PK | TRG);
    wait_words(3);
    @(posedge strobe);
    t0 = $realtime;
    @(posedge strobe);
    chk("strobe period ns", 32'd40, 32'(int'($realtime - t0)));
    hold <= 1'b1;
    cycles(12);
    n = i_fpdp_rx_model.words.size();
    cycles(40);
    chk("suspended count", 32'(n), cnt());
    hold <= 1'b0;
    wait_words(n + 8);
    chk("resumed", 32'h1, {31'h0, cnt() >= 32'(n + 8)});
    reg_wr(`FTX_OFS_CONTROL, PK);
    cycles(12);
    n = i_fpdp_rx_model.words.size();
    cycles(40);
    chk("disabled count", 32'(n), cnt());
    chk("disabled valid", 32'h0, {31'h0, valid});
    chk_stream(base, 4, 1'b1, 1'b1);
    reg_wr(`FTX_OFS_STROBE_DIV, 32'h0000_0001);
    $display("TEST repeating done");
    // Level trigger toggled mid-frame, frames of 5
    reg_wr(`FTX_OFS_FRAME_LEN, 32'h0000_0005);
    reg_wr(`FTX_OFS_CONTROL, EN | EXT | LVL | RPT | PK);
    i_fpdp_rx_model.clr();
    base = src_data;
    for (int t = 0; t < 3; t++) begin
      n = i_fpdp_rx_model.words.size();
      pin <= 1'b1;
      cycles(30 + 7 * t);
      pin <= 1'b0;
      cycles(8);
      chk("level grew", 32'h1, {31'h0, cnt() > 32'(n)});
      chk("level low valid", 32'h0, {31'h0, valid});
      n = i_fpdp_rx_model.words.size();
      cycles(40);
      chk("level low count", 32'(n), cnt());
    end
    chk_stream(base, 5, 1'b1, 1'b1);
    reg_wr(`FTX_OFS_CONTROL, 32'h0);
    $display("TEST level trigger done");
    // Enhanced select, legacy fallback, packed flag
    reg_wr(`FTX_OFS_CONTROL, ENH | PK);
    cycles(6);
    chk("enhanced", 32'h1, {31'h0, enh});
    chk("packed", 32'h1, {31'h0, packed_md});
    legacy <= 1'b1;
    cycles(6);
    chk("legacy fallback", 32'h0, {31'h0, enh});
    legacy <= 1'b0;
    reg_wr(`FTX_OFS_CONTROL, 32'h0);
    cycles(6);
    chk("legacy selected", 32'h0, {31'h0, enh});
    chk("unpacked", 32'h0, {31'h0, packed_md});
    $display("TEST modes done");
    stop_test();
  end
endmodule
`default_nettype wire
